// ---- design/prio_intc.sv ----
// Behaviour
// - request flag set by its source, held until software writes it clear.
// - flags set on their condition whatever the enable bit says.
// - a flagged request reaches arbitration only with its enable set.
// - each source holds a priority 1..7, seven highest.
// - priority zero never wins, same as a disabled source.
// - priority field is the low three bits of a nibble; top reads zero.
// - cpu level is four bits: bit 3 in core control, low three in status.
// - acceptance latches vector number and new level into accepted register.
// - nesting disable blocks any new interrupt while one is in service.
// - cpu level bits are read-only while nesting disable is one.
// - timed disable blocks levels 6 and below; its flag stays set meanwhile.
// - equal priorities pending together: lowest interrupt number wins.
// - assigned priority overrides natural order.
// - vector fetch address lies in the vector space 0x000004..0x0000FE.
// - fetched vector enters the pc through a 24-bit input mux.
// - normal fetch from vector space raises an address error trap.
// - control two holds pin edge selects and table choice; one holds traps.
// - up to 48 sources and 4 exceptions share one priority scheme.
`timescale 1ns/10ps
`default_nettype none
module prio_intc
   import intc_pkg::*;
(
   input  wire logic              mclk_in,
   input  wire logic              rst_n_in,
   input  wire logic              wb_cyc_in,
   input  wire logic              wb_stb_in,
   input  wire logic              wb_we_in,
   input  wire logic [7:0]        wb_adr_in,
   input  wire logic [3:0]        wb_sel_in,
   input  wire logic [31:0]       wb_dat_in,
   output logic      [31:0]       wb_dat_out,
   output logic                   wb_ack_out,
   input  wire logic [N_SRC-1:0]  src_event_in,
   input  wire logic [N_EXT-1:0]  ext_pin_in,
   input  wire logic [2:0]        trap_event_in,
   input  wire logic              fetch_valid_in,
   input  wire logic [23:0]       fetch_addr_in,
   input  wire logic              retire_in,
   input  wire logic              irq_ack_in,
   input  wire logic              irq_return_in,
   input  wire logic [3:0]        restore_level_in,
   input  wire logic [23:0]       pm_data_in,
   input  wire logic              pm_data_valid_in,
   input  wire logic [23:0]       seq_pc_in,
   output logic                   irq_req_out,
   output logic      [5:0]        irq_vec_out,
   output logic      [3:0]        irq_level_out,
   output logic      [3:0]        cpu_level_out,
   output logic                   vec_fetch_out,
   output logic      [23:0]       vec_addr_out,
   output logic                   pc_load_out,
   output logic      [23:0]       pc_out,
   output logic                   addr_err_out
);
   function automatic logic in_rng(input logic [7:0] adr,
                                   input logic [7:0] base,
                                   input int n);
      return (adr >= base) && ((adr - base) < 8'(4 * n));
   endfunction

   function automatic logic [3:0] widx(input logic [7:0] adr,
                                       input logic [7:0] base);
      return 4'((adr - base) >> 2);
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] nw,
                                         input logic [15:0] mask);
      return (old & ~mask) | (nw & mask);
   endfunction

   logic                 wb_ack;
   logic [N_SRC-1:0]     flags;
   logic [N_SRC-1:0]     enables;
   logic [4*N_SRC-1:0]   prio;
   logic [3:0]           cur_level;
   logic                 in_service;
   logic                 nest_dis;
   logic [N_TRAP-1:0]    trap_flags;
   logic [15:0]          con2;
   logic [13:0]          tdis_cnt;
   logic [5:0]           acc_vec;
   logic [3:0]           acc_level;
   logic [N_EXT-1:0]     ext_s1;
   logic [N_EXT-1:0]     ext_s2;
   logic [N_EXT-1:0]     ext_s3;
   pick_t                pick;
   pick_t                pick_q;
   fetch_state_t         state;
   logic [31:0]          rd_word;
   logic [N_SRC-1:0]     set_vec;
   logic [N_SRC-1:0]     next_flags;
   logic [N_SRC-1:0]     next_enables;
   logic [4*N_SRC-1:0]   next_prio;
   logic [3:0]           next_cur_level;
   logic [13:0]          next_tdis_cnt;

   // bus decode
   wire logic        bus_req   = wb_cyc_in & wb_stb_in & ~wb_ack;
   wire logic        wr_en     = bus_req & wb_we_in;
   wire logic        rd_en     = bus_req & ~wb_we_in;
   wire logic        aligned   = wb_adr_in[1:0] == 2'b00;
   wire logic        hit_flag  = aligned
                               & in_rng(wb_adr_in, FLAG_BASE, N_BANK);
   wire logic        hit_ena   = aligned
                               & in_rng(wb_adr_in, ENA_BASE, N_BANK);
   wire logic        hit_prio  = aligned
                               & in_rng(wb_adr_in, PRIO_BASE, N_PRIO_REG);
   wire logic [3:0]  flag_idx  = widx(wb_adr_in, FLAG_BASE);
   wire logic [3:0]  ena_idx   = widx(wb_adr_in, ENA_BASE);
   wire logic [3:0]  prio_idx  = widx(wb_adr_in, PRIO_BASE);
   wire logic        hit_stat  = wb_adr_in == STATUS_OFS;
   wire logic        hit_cc    = wb_adr_in == CORE_OFS;
   wire logic        hit_acc   = wb_adr_in == ACCEPT_OFS;
   wire logic        hit_con1  = wb_adr_in == CON1_OFS;
   wire logic        hit_con2  = wb_adr_in == CON2_OFS;
   wire logic        hit_disc  = wb_adr_in == DISCNT_OFS;
   wire logic [15:0] wmask     = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
   wire logic [15:0] wdat      = wb_dat_in[15:0];

   // core side
   wire logic        tdis_on   = tdis_cnt != 14'h0000;
   wire logic        alt_tbl   = con2[ALT_BIT];
   wire logic [N_EXT-1:0] ext_rise = ext_s2 & ~ext_s3;
   wire logic [N_EXT-1:0] ext_fall = ~ext_s2 & ext_s3;
   wire logic [N_EXT-1:0] ext_edge = (con2[N_EXT-1:0] & ext_fall)
                                   | (~con2[N_EXT-1:0] & ext_rise);
   wire logic        addr_err  = fetch_valid_in
                               & in_vspace(fetch_addr_in);
   wire logic [N_TRAP-1:0] trap_set = {addr_err, trap_event_in};
   wire logic [3:0]  floor     = (tdis_on && cur_level < TIMED_MAX_LEVEL)
                               ? TIMED_MAX_LEVEL : cur_level;
   wire logic [N_SRC-1:0] armed = flags & enables;
   wire logic        take      = irq_ack_in & irq_req_out;
   wire logic        vec_sel   = (state == S_FETCH) & pm_data_valid_in;
   wire logic [15:0] con1_rd   = {nest_dis, 11'h000, trap_flags};
   wire logic [15:0] con1_new  = merge(con1_rd, wdat, wmask & CON1_WR_MASK);
   wire logic [15:0] con2_new  = merge(con2, wdat, wmask & CON2_WR_MASK);
   wire logic [15:0] disc_new  = merge({2'b00, tdis_cnt}, wdat, wmask);

   // handshake: blocked during service with nesting disabled, or a fetch in flight
   assign irq_req_out   = pick_q.found & ~(nest_dis & in_service)
                        & (state == S_IDLE);
   assign irq_vec_out   = pick_q.vec;
   assign irq_level_out = pick_q.level;
   assign cpu_level_out = cur_level;
   assign vec_fetch_out = state == S_FETCH;
   assign wb_ack_out    = wb_ack;

   source_arbiter u_arb (
      .req_in   (armed),
      .prio_in  (prio),
      .trap_in  (trap_flags),
      .floor_in (floor),
      .pick_out (pick)
   );

   pc_input_mux u_pcmux (
      .mclk_in     (mclk_in),
      .rst_n_in    (rst_n_in),
      .seq_pc_in   (seq_pc_in),
      .vec_word_in (pm_data_in),
      .vec_sel_in  (vec_sel),
      .pc_out      (pc_out),
      .pc_load_out (pc_load_out)
   );

   // pin events join the peripheral events
   always_comb begin
      set_vec = src_event_in;
      for (int e = 0; e < N_EXT; e++) begin
         set_vec[EXT_NUM[e]] = set_vec[EXT_NUM[e]] | ext_edge[e];
      end
   end

   // software write first, then hardware set on top so a set wins
   always_comb begin
      next_flags   = flags;
      next_enables = enables;
      next_prio    = prio;
      for (int k = 0; k < N_BANK; k++) begin
         if (wr_en && hit_flag && flag_idx == 4'(k)) begin
            next_flags[16*k +: 16] = merge(flags[16*k +: 16], wdat, wmask);
         end
         if (wr_en && hit_ena && ena_idx == 4'(k)) begin
            next_enables[16*k +: 16] =
               merge(enables[16*k +: 16], wdat, wmask);
         end
      end
      for (int k = 0; k < N_PRIO_REG; k++) begin
         if (wr_en && hit_prio && prio_idx == 4'(k)) begin
            next_prio[16*k +: 16] = merge(prio[16*k +: 16], wdat,
                                          wmask & PRIO_FIELD_MASK);
         end
      end
      next_flags = next_flags | set_vec;
   end

   always_comb begin
      next_cur_level = cur_level;
      if (wr_en && hit_stat && !nest_dis && wb_sel_in[0]) begin
         next_cur_level[2:0] = wdat[STATUS_LVL_LSB +: 3];
      end
      if (wr_en && hit_cc && !nest_dis && wb_sel_in[0]) begin
         next_cur_level[3] = wdat[CORE_LVL_BIT];
      end
      if (take) begin
         next_cur_level = pick_q.level;
      end else if (irq_return_in) begin
         next_cur_level = restore_level_in;
      end
   end

   always_comb begin
      next_tdis_cnt = tdis_cnt;
      if (wr_en && hit_disc) begin
         next_tdis_cnt = disc_new[13:0];
      end else if (retire_in && tdis_on) begin
         next_tdis_cnt = tdis_cnt - 14'h0001;
      end
   end

   always_comb begin
      rd_word = '0;
      if (hit_flag) begin
         rd_word[15:0] = flags[16*flag_idx +: 16];
      end else if (hit_ena) begin
         rd_word[15:0] = enables[16*ena_idx +: 16];
      end else if (hit_prio) begin
         rd_word[15:0] = prio[16*prio_idx +: 16];
      end else if (hit_stat) begin
         rd_word[STATUS_LVL_LSB +: 3] = cur_level[2:0];
      end else if (hit_cc) begin
         rd_word[CORE_LVL_BIT] = cur_level[3];
      end else if (hit_acc) begin
         rd_word[5:0] = acc_vec;
         rd_word[VEC_LEVEL_LSB +: 4] = acc_level;
      end else if (hit_con1) begin
         rd_word[15:0] = con1_rd;
      end else if (hit_con2) begin
         rd_word[15:0] = con2;
         rd_word[TDIS_BIT] = tdis_on;
      end else if (hit_disc) begin
         rd_word[13:0] = tdis_cnt;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wb_ack     <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end else begin
         wb_ack <= bus_req;
         if (rd_en) begin
            wb_dat_out <= rd_word;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flags    <= '0;
         enables  <= '0;
         prio     <= '0;
         cur_level <= LVL_RESET;
         tdis_cnt <= 14'h0000;
      end else begin
         flags    <= next_flags;
         enables  <= next_enables;
         prio     <= next_prio;
         cur_level <= next_cur_level;
         tdis_cnt <= next_tdis_cnt;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         nest_dis   <= 1'b0;
         trap_flags <= '0;
         con2       <= 16'h0000;
      end else begin
         if (wr_en && hit_con1) begin
            nest_dis   <= con1_new[NEST_BIT];
            trap_flags <= con1_new[N_TRAP-1:0] | trap_set;
         end else begin
            trap_flags <= trap_flags | trap_set;
         end
         if (wr_en && hit_con2) begin
            con2 <= con2_new;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ext_s1 <= '0;
         ext_s2 <= '0;
         ext_s3 <= '0;
      end else begin
         ext_s1 <= ext_pin_in;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pick_q       <= '0;
         in_service   <= 1'b0;
         acc_vec      <= 6'h00;
         acc_level    <= 4'h0;
         state        <= S_IDLE;
         vec_addr_out <= 24'h00_0000;
         addr_err_out <= 1'b0;
      end else begin
         pick_q       <= pick;
         addr_err_out <= addr_err;
         if (take) begin
            in_service <= 1'b1;
            acc_vec    <= pick_q.vec;
            acc_level  <= pick_q.level;
         end else if (irq_return_in) begin
            in_service <= 1'b0;
         end
         case (state)
            S_IDLE: begin
               if (take) begin
                  state        <= S_FETCH;
                  vec_addr_out <= vector_addr(alt_tbl, pick_q.vec);
               end
            end
            S_FETCH: begin
               if (pm_data_valid_in) begin
                  state <= S_IDLE;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("bus ack held longer than one cycle");
   flag_hold_a: assert property (!(wr_en && hit_flag)
      |=> (flags & $past(flags)) == $past(flags))
      else $error("request flag dropped without a write");
   flag_set_a: assert property (1'b1
      |=> (flags & $past(src_event_in)) == $past(src_event_in))
      else $error("source event did not set its flag");
   prio_top_a: assert property ((prio & {N_SRC{4'h8}}) == '0)
      else $error("priority nibble top bit set");
   nest_block_a: assert property (nest_dis && in_service |-> !irq_req_out)
      else $error("request offered while nesting disabled");
   level_lock_a: assert property (nest_dis && !irq_ack_in && !irq_return_in
      |=> cpu_level_out == $past(cpu_level_out))
      else $error("cpu level changed while locked");
   timed_block_a: assert property (tdis_on && pick.found
      |-> pick.level > TIMED_MAX_LEVEL)
      else $error("low level passed during timed disable");
   above_level_a: assert property (pick.found |-> pick.level > cur_level)
      else $error("pick not above cpu level");
   accept_latch_a: assert property (take |=> acc_vec == $past(irq_vec_out)
      && acc_level == $past(irq_level_out) && vec_fetch_out)
      else $error("accepted vector not latched");
   addr_trap_a: assert property (addr_err
      |=> addr_err_out && trap_flags[ADDR_ERR_TRAP])
      else $error("vector space fetch raised no trap");
   vec_range_a: assert property (vec_fetch_out
      |-> vec_addr_out >= VSPACE_LO && vec_addr_out <= VSPACE_HI + 24'h2)
      else $error("vector address outside vector space");
   zero_prio_a: assert property (pick.found && pick.level < 4'h8
      |-> pick.level != 4'h0)
      else $error("priority zero source taken");
endmodule
`default_nettype wire

// ---- design/intc_pkg.sv ----
`default_nettype none
package intc_pkg;
   localparam int N_SRC      = 48;
   localparam int N_BANK     = 3;
   localparam int N_PRIO_REG = 12;
   localparam int N_TRAP     = 4;
   localparam int N_EXT      = 5;
   localparam int EXT_NUM [N_EXT] = '{0, 16, 23, 36, 37};

   localparam logic [7:0] FLAG_BASE   = 8'h00;
   localparam logic [7:0] ENA_BASE    = 8'h0C;
   localparam logic [7:0] PRIO_BASE   = 8'h18;
   localparam logic [7:0] STATUS_OFS  = 8'h48;
   localparam logic [7:0] CORE_OFS    = 8'h4C;
   localparam logic [7:0] ACCEPT_OFS  = 8'h50;
   localparam logic [7:0] CON1_OFS    = 8'h54;
   localparam logic [7:0] CON2_OFS    = 8'h58;
   localparam logic [7:0] DISCNT_OFS  = 8'h5C;

   localparam int NEST_BIT       = 15;
   localparam int TDIS_BIT       = 14;
   localparam int ALT_BIT        = 15;
   localparam int STATUS_LVL_LSB = 5;
   localparam int CORE_LVL_BIT   = 3;
   localparam int VEC_LEVEL_LSB  = 8;
   localparam int ADDR_ERR_TRAP  = 3;

   localparam logic [15:0] PRIO_FIELD_MASK = 16'h7777;
   localparam logic [15:0] CON2_WR_MASK    = 16'h801F;
   localparam logic [15:0] CON1_WR_MASK    = 16'h800F;
   localparam logic [3:0]  TIMED_MAX_LEVEL = 4'h6;
   localparam logic [3:0]  TRAP_TOP_LEVEL  = 4'hF;
   localparam logic [3:0]  LVL_RESET       = 4'h0;
   localparam logic [5:0]  VEC_OFFSET      = 6'h08;
   localparam logic [5:0]  TRAP_VEC_FIRST  = 6'h01;
   localparam logic [23:0] PRI_TBL_BASE    = 24'h00_0004;
   localparam logic [23:0] ALT_TBL_BASE    = 24'h00_0084;
   localparam logic [23:0] VSPACE_LO       = 24'h00_0004;
   localparam logic [23:0] VSPACE_HI       = 24'h00_00FE;

   typedef struct packed {
      logic       found;
      logic [5:0] vec;
      logic [3:0] level;
   } pick_t;

   typedef enum logic {S_IDLE, S_FETCH} fetch_state_t;

   function automatic logic [23:0] vector_addr(input logic alt,
                                               input logic [5:0] vec);
      return (alt ? ALT_TBL_BASE : PRI_TBL_BASE) + {17'h0_0000, vec, 1'b0};
   endfunction

   function automatic logic in_vspace(input logic [23:0] addr);
      return (addr >= VSPACE_LO) && (addr <= VSPACE_HI);
   endfunction
endpackage
`default_nettype wire

// ---- design/source_arbiter.sv ----
`timescale 1ns/10ps
`default_nettype none
module source_arbiter
   import intc_pkg::*;
(
   input  wire logic [N_SRC-1:0]   req_in,
   input  wire logic [4*N_SRC-1:0] prio_in,
   input  wire logic [N_TRAP-1:0]  trap_in,
   input  wire logic [3:0]         floor_in,
   output var pick_t               pick_out
);
   logic [3:0] lv;

   // descending scan with >= lets the lower number win a tie
   always_comb begin
      pick_out = '0;
      lv = '0;
      for (int i = N_SRC - 1; i >= 0; i--) begin
         lv = {1'b0, prio_in[4*i +: 3]};
         if (req_in[i] && lv > floor_in && lv >= pick_out.level) begin
            pick_out.found = 1'b1;
            pick_out.vec   = 6'(i) + VEC_OFFSET;
            pick_out.level = lv;
         end
      end
      for (int t = N_TRAP - 1; t >= 0; t--) begin
         lv = TRAP_TOP_LEVEL - 4'(t);
         if (trap_in[t] && lv > floor_in) begin
            pick_out.found = 1'b1;
            pick_out.vec   = 6'(t) + TRAP_VEC_FIRST;
            pick_out.level = lv;
         end
      end
   end
endmodule
`default_nettype wire

// ---- design/pc_input_mux.sv ----
`timescale 1ns/10ps
`default_nettype none
module pc_input_mux
   import intc_pkg::*;
(
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   input  wire logic [23:0] seq_pc_in,
   input  wire logic [23:0] vec_word_in,
   input  wire logic        vec_sel_in,
   output logic      [23:0] pc_out,
   output logic             pc_load_out
);
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pc_out      <= 24'h00_0000;
         pc_load_out <= 1'b0;
      end else begin
         pc_out      <= vec_sel_in ? vec_word_in : seq_pc_in;
         pc_load_out <= vec_sel_in;
      end
   end

   vec_load_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      vec_sel_in |=> pc_load_out && pc_out == $past(vec_word_in))
      else $error("vector word not loaded into pc");
endmodule
`default_nettype wire

// ---- test/core_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module core_model (
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   input  wire logic        take_in,
   input  wire logic        irq_req_in,
   input  wire logic        vec_fetch_in,
   input  wire logic [23:0] vec_addr_in,
   output logic             irq_ack_out,
   output logic             pm_valid_out,
   output logic      [23:0] pm_data_out
);
   logic [1:0] lag;
   // vector word arrives three cycles into the fetch; bus toggles otherwise
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_ack_out  <= 1'b0;
         pm_valid_out <= 1'b0;
         pm_data_out  <= 24'h00_0000;
         lag          <= 2'h0;
      end else begin
         irq_ack_out  <= take_in && irq_req_in && !irq_ack_out;
         pm_valid_out <= 1'b0;
         pm_data_out  <= ~pm_data_out;
         lag          <= 2'h0;
         if (vec_fetch_in && !pm_valid_out) begin
            lag <= lag + 2'h1;
            if (lag == 2'h2) begin
               pm_valid_out <= 1'b1;
               pm_data_out  <= vec_addr_in ^ 24'hA5_0000;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- test/prio_intc_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module prio_intc_tb_top
   import intc_pkg::*;
;
   logic             mclk_in  = 1'b0;
   logic             rst_n_in = 1'b0;
   logic             cyc      = 1'b0;
   logic             we       = 1'b0;
   logic             take     = 1'b0;
   logic             fv       = 1'b0;
   logic             retire   = 1'b0;
   logic             ret      = 1'b0;
   logic [7:0]       adr      = 8'h00;
   logic [15:0]      dat      = 16'h0000;
   logic [N_SRC-1:0] ev       = '0;
   logic [N_EXT-1:0] pin      = '0;
   logic [2:0]       tev      = 3'h0;
   logic [23:0]      faddr    = 24'h00_0000;
   logic             ack, pmv, irq_req, vec_fetch, pc_load, addr_err;
   logic             irq_ack;
   logic [31:0]      rdat;
   logic [5:0]       irq_vec;
   logic [3:0]       irq_level, cpu_level;
   logic [23:0]      vaddr, pc, pmd;
   int               err_total = 0;
   int               checks    = 0;
   int               ticks     = 0;

   initial forever #2 mclk_in = ~mclk_in;

   prio_intc prio_intc_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(4'h3), .wb_dat_in({16'h0000, dat}), .wb_dat_out(rdat),
      .wb_ack_out(ack), .src_event_in(ev), .ext_pin_in(pin),
      .trap_event_in(tev), .fetch_valid_in(fv), .fetch_addr_in(faddr),
      .retire_in(retire), .irq_ack_in(irq_ack), .irq_return_in(ret),
      .restore_level_in(4'h0), .pm_data_in(pmd), .pm_data_valid_in(pmv),
      .seq_pc_in(24'h00_0200), .irq_req_out(irq_req),
      .irq_vec_out(irq_vec), .irq_level_out(irq_level),
      .cpu_level_out(cpu_level), .vec_fetch_out(vec_fetch),
      .vec_addr_out(vaddr), .pc_load_out(pc_load), .pc_out(pc),
      .addr_err_out(addr_err));

   core_model core_model_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .take_in(take), .irq_req_in(irq_req), .vec_fetch_in(vec_fetch),
      .vec_addr_in(vaddr), .irq_ack_out(irq_ack), .pm_valid_out(pmv),
      .pm_data_out(pmd));

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   always @(posedge mclk_in) begin
      ticks++;
      if (ticks == 20000) begin
         err_total++;
         complete_run();
      end
   end

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
      @(posedge mclk_in);
      cyc <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge mclk_in);
      end while (ack !== 1'b1);
      cyc <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      wb(1'b1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [15:0] e);
      wb(1'b0, a, 16'h0000);
      chk(rdat[15:0], e);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge mclk_in);
   endtask

   task automatic pulse(input logic [N_SRC-1:0] m);
      @(posedge mclk_in);
      ev <= m;
      @(posedge mclk_in);
      ev <= '0;
   endtask

   task automatic quiet(input logic e);
      idle(6);
      @(negedge mclk_in);
      chk(irq_req, e);
   endtask

   // waits for the pc load, then checks pc and the accepted register
   task automatic accept(input logic [5:0] v, input logic [3:0] l,
                         input logic alt);
      logic [23:0] a;
      a = (alt ? ALT_TBL_BASE : PRI_TBL_BASE) + {17'h0_0000, v, 1'b0};
      do begin
         @(posedge mclk_in);
      end while (pc_load !== 1'b1);
      chk(pc, a ^ 24'hA5_0000);
      rdc(ACCEPT_OFS, {4'h0, l, 2'b00, v});
   endtask

   // flags are not cleared by acceptance, so clear before returning
   task automatic back();
      wr(FLAG_BASE, 16'h0000);
      wr(FLAG_BASE + 8'h08, 16'h0000);
      @(posedge mclk_in);
      ret <= 1'b1;
      @(posedge mclk_in);
      ret <= 1'b0;
   endtask

   initial begin
      idle(20);
      rst_n_in <= 1'b1;
      rdc(ACCEPT_OFS, 16'h0000);
      rdc(8'hFC, 16'h0000);
      wr(PRIO_BASE, 16'hFFFF);
      rdc(PRIO_BASE, 16'h7777);
      pulse(48'h0000_0000_0004);
      rdc(FLAG_BASE, 16'h0004);
      quiet(1'b0);
      rdc(FLAG_BASE, 16'h0004);
      wr(FLAG_BASE, 16'h0000);
      rdc(FLAG_BASE, 16'h0000);
      wr(PRIO_BASE, 16'h0000);
      wr(ENA_BASE, 16'h0004);
      pulse(48'h0000_0000_0004);
      quiet(1'b0);
      wr(PRIO_BASE, 16'h3330);
      wr(FLAG_BASE, 16'h0000);
      wr(ENA_BASE, 16'h000E);
      take <= 1'b1;
      pulse(48'h0000_0000_000E);
      accept(6'd9, 4'h3, 1'b0);
      back();
      wr(PRIO_BASE, 16'h0010);
      wr(PRIO_BASE + 8'h28, 16'h0700);
      wr(ENA_BASE + 8'h08, 16'h0400);
      pulse(48'h0400_0000_0002);
      accept(6'd50, 4'h7, 1'b0);
      back();
      take <= 1'b0;
      wr(STATUS_OFS, 16'h0060);
      wr(PRIO_BASE, 16'h0030);
      pulse(48'h0000_0000_0002);
      quiet(1'b0);
      wr(PRIO_BASE, 16'h0040);
      quiet(1'b1);
      chk(irq_level, 4'h4);
      wr(CON1_OFS, 16'h8000);
      wr(STATUS_OFS, 16'h0000);
      chk(cpu_level, 4'h3);
      take <= 1'b1;
      accept(6'd9, 4'h4, 1'b0);
      rdc(STATUS_OFS, 16'h0080);
      pulse(48'h0400_0000_0000);
      quiet(1'b0);
      back();
      wr(CON1_OFS, 16'h0000);
      take <= 1'b0;
      wr(PRIO_BASE, 16'h0060);
      wr(DISCNT_OFS, 16'h0002);
      rdc(CON2_OFS, 16'h4000);
      pulse(48'h0000_0000_0002);
      quiet(1'b0);
      @(posedge mclk_in);
      retire <= 1'b1;
      idle(2);
      retire <= 1'b0;
      quiet(1'b1);
      rdc(CON2_OFS, 16'h0000);
      wr(CON2_OFS, 16'h8000);
      take <= 1'b1;
      accept(6'd9, 4'h6, 1'b1);
      back();
      take <= 1'b0;
      @(posedge mclk_in);
      fv    <= 1'b1;
      faddr <= 24'h00_0010;
      @(posedge mclk_in);
      fv <= 1'b0;
      @(negedge mclk_in);
      chk(addr_err, 1'b1);
      rdc(CON1_OFS, 16'h0008);
      quiet(1'b1);
      chk(irq_vec, 6'd4);
      @(posedge mclk_in);
      tev <= 3'h1;
      @(posedge mclk_in);
      tev <= 3'h0;
      quiet(1'b1);
      chk(irq_vec, 6'd1);
      chk(irq_level, TRAP_TOP_LEVEL);
      // pin 0 rising edge, then falling edge once selected
      @(posedge mclk_in);
      pin <= 5'h01;
      idle(4);
      rdc(FLAG_BASE, 16'h0001);
      wr(FLAG_BASE, 16'h0000);
      wr(CON2_OFS, 16'h0001);
      pin <= 5'h00;
      idle(4);
      rdc(FLAG_BASE, 16'h0001);
      complete_run();
   end
endmodule
`default_nettype wire
